//--- src/thbp_params.svh
`ifndef THBP_PARAMS_SVH
`define THBP_PARAMS_SVH

// ****************************************
// Register addresses
// ****************************************
`define THBP_ADDR_W 3
`define THBP_ADDR_TCTL 3'h0
`define THBP_ADDR_PERIOD 3'h1
`define THBP_ADDR_COUNT 3'h2
`define THBP_ADDR_DBAND 3'h3
`define THBP_ADDR_DUTY 3'h4
`define THBP_ADDR_DIR 3'h5
`define THBP_ADDR_STATUS 3'h6

// ****************************************
// Field positions
// ****************************************
`define THBP_TCTL_POST_MSB 6
`define THBP_TCTL_POST_LSB 3
`define THBP_TCTL_EN 2
`define THBP_TCTL_PRE_MSB 1
`define THBP_TCTL_PRE_LSB 0
`define THBP_TCTL_MASK 8'h7f
`define THBP_DBAND_MSB 6
`define THBP_DIR_PRI 0
`define THBP_DIR_SEC 1

// ****************************************
// Reset values
// ****************************************
`define THBP_RST_TCTL 8'h00
`define THBP_RST_PERIOD 8'hff
`define THBP_RST_COUNT 8'h00
`define THBP_RST_DBAND 7'h00
`define THBP_RST_DUTY 8'h00
`define THBP_RST_DIR 2'h3
`define THBP_RST_STATUS 8'h00

// ****************************************
// Prescaler terminal counts
// ****************************************
`define THBP_PRE_CODE_DIV1 2'h0
`define THBP_PRE_CODE_DIV4 2'h1
`define THBP_PRE_LIM_DIV1 4'h0
`define THBP_PRE_LIM_DIV4 4'h3
`define THBP_PRE_LIM_DIV16 4'hf

`endif

//--- src/thbp_pkg.sv
package thbp_pkg;

	// ****************************************
	// Shared types
	// ****************************************
	typedef logic [7:0] thbp_byte_t;
	typedef logic [6:0] thbp_delay_t;
	typedef logic [3:0] thbp_nibble_t;

endpackage

//--- src/thbp_dband_if.sv
`timescale 1ns/10ps

// Raw waveform in, dead-band delayed waveform out
interface thbp_dband_if;
	logic raw;
	thbp_pkg::thbp_delay_t delay;
	logic out;

	modport ctrl (output raw, output delay, input out);
	modport dband (input raw, input delay, output out);
endinterface

//--- src/thbp_deadband.sv
`timescale 1ns/10ps

module thbp_deadband (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Waveform channel
	thbp_dband_if.dband dbIf
);

	thbp_pkg::thbp_delay_t cnt_q;
	thbp_pkg::thbp_delay_t cnt_d;
	logic out_q;
	logic out_d;

	// Count cycles since raw went active; drop out when raw drops
	always_comb begin
		cnt_d = '0;
		out_d = 1'b0;
		if (dbIf.raw) begin
			if (cnt_q == dbIf.delay) begin
				cnt_d = cnt_q;
				out_d = 1'b1; // R05
			end else begin
				cnt_d = cnt_q + 7'h01; // R06
			end
		end
	end

	// State registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			cnt_q <= '0;
			out_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			out_q <= out_d;
		end
	end

	assign dbIf.out = out_q;

endmodule

//--- src/thbp_timer_halfbridge.sv
// Summary of operation
// R01 - Match events are divided by the post-divide field value plus one.
// R02 - The 8-bit timer count is readable, writable and resets to zero.
// R03 - The half-bridge stage drives exactly two output pins.
// R04 - Primary pin carries the PWM wave, secondary its complement.
// R05 - Each output turns active only after the dead-band cycle count.
// R06 - A dead band longer than the active time keeps that output off.
// R07 - Each pin is driven only while its direction bit selects output.
// R08 - The timer counts while enabled, prescaled by 1, 4 or 16.
`timescale 1ns/10ps
`include "thbp_params.svh"

module thbp_timer_halfbridge (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Register port
	input wire logic [`THBP_ADDR_W-1:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	output logic [7:0] regRdData,
	// Timer event
	output logic periodEvent,
	// Half-bridge pins
	output logic bridgeOutPrimary,
	output logic bridgeOutPrimaryOe,
	output logic bridgeOutSecondary,
	output logic bridgeOutSecondaryOe
);

	// ****************************************
	// Registers
	// ****************************************

	// Each register keeps its value in a _q flop and takes its next
	// value from the single next-state block below; the read data flop
	// is cleared in every cycle that follows no read.
	thbp_pkg::thbp_byte_t ctl_q, ctl_d;
	thbp_pkg::thbp_byte_t period_q, period_d;
	thbp_pkg::thbp_byte_t count_q, count_d;
	thbp_pkg::thbp_delay_t dband_q, dband_d;
	thbp_pkg::thbp_byte_t duty_q, duty_d;
	logic [1:0] dir_q, dir_d;
	thbp_pkg::thbp_byte_t status_q, status_d;
	thbp_pkg::thbp_nibble_t pre_q, pre_d;
	thbp_pkg::thbp_nibble_t post_q, post_d;
	thbp_pkg::thbp_byte_t rd_q, rd_d;
	logic event_q, event_d;

	// ****************************************
	// Timer datapath
	// ****************************************
	logic countEnable;
	logic [1:0] preDivideSel;
	thbp_pkg::thbp_nibble_t postDivideSel;
	thbp_pkg::thbp_nibble_t preLimit;
	logic tick;
	logic match;
	logic postHit;
	logic pwmRaw;
	logic [1:0] bridgeOut;

	// The prescaler phase runs from zero up to its terminal count, and
	// a tick is the cycle in which it sits at that count. Changing the
	// select code mid-count can leave the phase above the new limit; it
	// then wraps through its full range once before it settles.

	// Control fields
	assign countEnable = ctl_q[`THBP_TCTL_EN];
	assign preDivideSel = ctl_q[`THBP_TCTL_PRE_MSB:`THBP_TCTL_PRE_LSB];
	assign postDivideSel = ctl_q[`THBP_TCTL_POST_MSB:`THBP_TCTL_POST_LSB];

	// Prescaler terminal count from select code
	always_comb begin
		case (preDivideSel)
			`THBP_PRE_CODE_DIV1: preLimit = `THBP_PRE_LIM_DIV1; // R08
			`THBP_PRE_CODE_DIV4: preLimit = `THBP_PRE_LIM_DIV4; // R08
			default: preLimit = `THBP_PRE_LIM_DIV16; // R08
		endcase
	end

	// Timer events. A match is a tick with the count at the period, and
	// the postscaler only advances on matches, so its ratio multiplies
	// the prescale ratio and the period length.
	assign tick = countEnable && (pre_q == preLimit); // R08
	assign match = tick && (count_q == period_q);
	assign postHit = match && (post_q == postDivideSel); // R01
	// Raw wave is high while the count is below the duty value: a duty
	// of zero keeps it low, a duty above the period keeps it high
	assign pwmRaw = count_q < duty_q;

	// Next-state of timer and register file
	always_comb begin
		ctl_d = ctl_q;
		period_d = period_q;
		count_d = count_q;
		dband_d = dband_q;
		duty_d = duty_q;
		dir_d = dir_q;
		status_d = status_q;
		pre_d = pre_q;
		post_d = post_q;
		rd_d = 8'h00;
		event_d = postHit;
		// Prescaler runs only while enabled; a cleared enable freezes
		// both the prescaler and the count where they stand
		if (countEnable) begin
			pre_d = (pre_q == preLimit) ? 4'h0 : pre_q + 4'h1; // R08
		end
		// Count up, wrap to zero on period match
		if (tick) begin
			count_d = match ? 8'h00 : count_q + 8'h01; // R08
		end
		// Postscaler counts match events and restarts on the one that
		// produces the postscaled pulse
		if (match) begin
			post_d = postHit ? 4'h0 : post_q + 4'h1; // R01
		end
		// Sticky postscaled event: write one to clear, but a new event
		// in the same cycle wins so that no event is ever lost
		if (regWrite && regAddr == `THBP_ADDR_STATUS) begin
			status_d = status_q & ~regWrData;
		end
		if (postHit) begin
			status_d[0] = 1'b1;
		end
		// Software writes to the count win over the timer's own update; a count write
		// also restarts the prescaler so the next tick is a full prescale period away
		if (regWrite) begin
			case (regAddr)
				`THBP_ADDR_TCTL: ctl_d = regWrData & `THBP_TCTL_MASK;
				`THBP_ADDR_PERIOD: period_d = regWrData;
				`THBP_ADDR_COUNT: begin
					count_d = regWrData; // R02
					pre_d = 4'h0;
				end
				`THBP_ADDR_DBAND: dband_d = regWrData[`THBP_DBAND_MSB:0];
				`THBP_ADDR_DUTY: duty_d = regWrData;
				`THBP_ADDR_DIR: dir_d = regWrData[1:0];
				default: ;
			endcase
		end
		// Read data for the following cycle only; outside that cycle
		// the read port shows zero so stale data never lingers
		if (regRead) begin
			case (regAddr)
				`THBP_ADDR_TCTL: rd_d = ctl_q;
				`THBP_ADDR_PERIOD: rd_d = period_q;
				`THBP_ADDR_COUNT: rd_d = count_q; // R02
				`THBP_ADDR_DBAND: rd_d = {1'b0, dband_q};
				`THBP_ADDR_DUTY: rd_d = duty_q;
				`THBP_ADDR_DIR: rd_d = {6'h00, dir_q};
				`THBP_ADDR_STATUS: rd_d = status_q;
				default: rd_d = 8'h00;
			endcase
		end
	end

	// State registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			ctl_q <= `THBP_RST_TCTL;
			period_q <= `THBP_RST_PERIOD;
			count_q <= `THBP_RST_COUNT; // R02
			dband_q <= `THBP_RST_DBAND;
			duty_q <= `THBP_RST_DUTY;
			dir_q <= `THBP_RST_DIR;
			status_q <= `THBP_RST_STATUS;
			pre_q <= 4'h0;
			post_q <= 4'h0;
			rd_q <= 8'h00;
			event_q <= 1'b0;
		end else begin
			ctl_q <= ctl_d;
			period_q <= period_d;
			count_q <= count_d;
			dband_q <= dband_d;
			duty_q <= duty_d;
			dir_q <= dir_d;
			status_q <= status_d;
			pre_q <= pre_d;
			post_q <= post_d;
			rd_q <= rd_d;
			event_q <= event_d;
		end
	end

	// Both data outputs come straight from flops
	assign regRdData = rd_q;
	assign periodEvent = event_q;

	// ****************************************
	// Half-bridge output stage
	// ****************************************

	// One dead-band channel per pin, primary then complement. Both
	// channels are registered, so even with no dead band each pin lags
	// the compare by one cycle; the lag is equal on both pins, which
	// keeps the two from ever being high together.
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : gChan
			thbp_dband_if dbIf ();
			assign dbIf.raw = (g == 0) ? pwmRaw : ~pwmRaw; // R04
			assign dbIf.delay = dband_q; // R05
			assign bridgeOut[g] = dbIf.out;
			thbp_deadband uDband (
				.clock(clock),
				.rst(rst),
				.dbIf(dbIf.dband)
			);
		end
	endgenerate

	// Two pins, each enabled by its direction bit. Direction resets to
	// input, so neither switch is driven until software clears its bit;
	// a pin left as input falls to whatever pull sits on the board.
	assign bridgeOutPrimary = bridgeOut[0]; // R03
	assign bridgeOutSecondary = bridgeOut[1]; // R03
	assign bridgeOutPrimaryOe = ~dir_q[`THBP_DIR_PRI]; // R07
	assign bridgeOutSecondaryOe = ~dir_q[`THBP_DIR_SEC]; // R07

endmodule

//--- testbench/thbp_props.sv
`timescale 1ns/10ps
`include "thbp_params.svh"

module thbp_props (
	// Clock and reset
	input wire logic clock,
	input wire logic rst,
	// Register port
	input wire logic [`THBP_ADDR_W-1:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regRdData,
	// Outputs
	input wire logic periodEvent,
	input wire logic bridgeOutPrimary,
	input wire logic bridgeOutPrimaryOe,
	input wire logic bridgeOutSecondary,
	input wire logic bridgeOutSecondaryOe
);
	default clocking @(posedge clock);
	endclocking
	default disable iff (rst);

	// ****
	// Register port and pin checks
	// ****
	property p_rdIdle;
		!regRead |=> regRdData == 8'h00;
	endproperty
	a_rdIdle: assert property (p_rdIdle) else $error("rd idle");
	property p_unmapped;
		regRead && regAddr == 3'h7 |=> regRdData == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped");
	property p_ctlTop;
		regRead && regAddr == `THBP_ADDR_TCTL |=> !regRdData[7];
	endproperty
	a_ctlTop: assert property (p_ctlTop) else $error("ctl bit7");
	property p_periodRw;
		regWrite && regAddr == `THBP_ADDR_PERIOD ##2
		regRead && regAddr == `THBP_ADDR_PERIOD
		|=> regRdData == $past(regWrData, 3);
	endproperty
	a_periodRw: assert property (p_periodRw) else $error("period");
	property p_dbandRw;
		regWrite && regAddr == `THBP_ADDR_DBAND ##2
		regRead && regAddr == `THBP_ADDR_DBAND
		|=> regRdData == ($past(regWrData, 3) & 8'h7f);
	endproperty
	a_dbandRw: assert property (p_dbandRw) else $error("dband");
	property p_oeOn;
		regWrite && regAddr == `THBP_ADDR_DIR
		|=> bridgeOutPrimaryOe == !$past(regWrData[0])
		&& bridgeOutSecondaryOe == !$past(regWrData[1]);
	endproperty
	a_oeOn: assert property (p_oeOn) else $error("oe set");
	property p_oeHold;
		!(regWrite && regAddr == `THBP_ADDR_DIR)
		|=> $stable(bridgeOutPrimaryOe) && $stable(bridgeOutSecondaryOe);
	endproperty
	a_oeHold: assert property (p_oeHold) else $error("oe hold");
	property p_noShoot;
		!(bridgeOutPrimary && bridgeOutSecondary);
	endproperty
	a_noShoot: assert property (p_noShoot) else $error("overlap");
endmodule

bind thbp_timer_halfbridge thbp_props props (.clock, .rst, .regAddr,
	.regWrData, .regWrite, .regRead, .regRdData, .periodEvent,
	.bridgeOutPrimary, .bridgeOutPrimaryOe, .bridgeOutSecondary,
	.bridgeOutSecondaryOe);

//--- testbench/thbp_switch_model.sv
`timescale 1ns/10ps

module thbp_switch_model (
	// Bridge pins
	input wire logic pri,
	input wire logic priOe,
	input wire logic sec,
	input wire logic secOe,
	// Gate levels at the switches
	output logic gateHi,
	output logic gateLo
);
	// Undriven pin falls to the pull-down, high side on primary
	assign gateHi = priOe ? pri : 1'b0;
	assign gateLo = secOe ? sec : 1'b0;
endmodule

//--- testbench/testbench.sv
`timescale 1ns/10ps
`include "thbp_params.svh"

module testbench;
	logic clock, rst, regWrite, regRead, periodEvent;
	logic [2:0] regAddr;
	logic [7:0] regWrData, regRdData;
	logic pri, priOe, sec, secOe, gateHi, gateLo;
	int bad_count = 0;
	int check_count = 0;

	thbp_timer_halfbridge uut (.clock, .rst, .regAddr, .regWrData,
		.regWrite, .regRead, .regRdData, .periodEvent,
		.bridgeOutPrimary(pri), .bridgeOutPrimaryOe(priOe),
		.bridgeOutSecondary(sec), .bridgeOutSecondaryOe(secOe));
	thbp_switch_model drv (.pri, .priOe, .sec, .secOe, .gateHi, .gateLo);

	// Clock
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// ****
	// Bus and compare tasks
	// ****
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1;
		check(regRdData, exp);
		@(posedge clock);
	endtask

	// ****
	// Scenarios
	// ****
	task automatic t_reset();
		rdc(`THBP_ADDR_TCTL, `THBP_RST_TCTL);
		rdc(`THBP_ADDR_PERIOD, `THBP_RST_PERIOD);
		rdc(`THBP_ADDR_COUNT, `THBP_RST_COUNT);
		rdc(`THBP_ADDR_DBAND, 8'h00);
		rdc(`THBP_ADDR_DIR, 8'h03);
		rdc(3'h7, 8'h00);
		wr(`THBP_ADDR_COUNT, 8'h5a);
		rdc(`THBP_ADDR_COUNT, 8'h5a);
		wr(`THBP_ADDR_PERIOD, 8'ha5);
		rdc(`THBP_ADDR_PERIOD, 8'ha5);
		wr(`THBP_ADDR_DBAND, 8'hff);
		rdc(`THBP_ADDR_DBAND, 8'h7f);
		wr(`THBP_ADDR_TCTL, 8'hff);
		rdc(`THBP_ADDR_TCTL, 8'h7f);
		wr(`THBP_ADDR_TCTL, 8'h00);
		$display("reset test done");
	endtask
	// Event spacing for period 3 under a given control value
	task automatic t_rate(input logic [7:0] ctl, input logic [15:0] span);
		int n;
		wr(`THBP_ADDR_PERIOD, 8'h03);
		wr(`THBP_ADDR_COUNT, 8'h00);
		wr(`THBP_ADDR_TCTL, ctl);
		for (int k = 0; k < 2; k++) begin
			n = 0;
			do begin
				@(posedge clock);
				#1;
				n++;
			end while (periodEvent !== 1'b1 && n < 3000);
		end
		check(n[15:0], span);
		@(posedge clock);
		#1;
		check({15'h0000, periodEvent}, 16'h0000);
		wr(`THBP_ADDR_TCTL, 8'h00);
		rdc(`THBP_ADDR_STATUS, 8'h01);
		wr(`THBP_ADDR_STATUS, 8'h01);
		rdc(`THBP_ADDR_STATUS, 8'h00);
		$display("rate test done");
	endtask
	// Bridge high cycles per ten-cycle period, duty five
	task automatic t_bridge(input logic [7:0] dir, input logic [6:0] db,
		input logic [15:0] hi);
		logic [15:0] nh, nl;
		wr(`THBP_ADDR_PERIOD, 8'h09);
		wr(`THBP_ADDR_DUTY, 8'h05);
		wr(`THBP_ADDR_DBAND, {1'b0, db});
		wr(`THBP_ADDR_DIR, dir);
		wr(`THBP_ADDR_TCTL, 8'h04);
		repeat (20) @(posedge clock);
		nh = 16'h0000;
		nl = 16'h0000;
		repeat (10) begin
			@(posedge clock);
			#1;
			nh += gateHi;
			nl += gateLo;
		end
		check(nh, hi);
		check(nl, hi);
		rdc(`THBP_ADDR_DUTY, 8'h05);
		wr(`THBP_ADDR_TCTL, 8'h00);
		$display("bridge test done");
	endtask

	// Verdict
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// Main sequence
	initial begin
		rst = 1'b1;
		regAddr = 3'h0;
		regWrData = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		t_reset();
		t_rate(8'h04, 16'h0004);
		t_rate(8'h05, 16'h0010);
		t_rate(8'h06, 16'h0040);
		t_rate(8'h0c, 16'h0008);
		t_rate(8'h7f, 16'h0400);
		t_bridge(8'h00, 7'h00, 16'h0005);
		t_bridge(8'h00, 7'h02, 16'h0003);
		t_bridge(8'h00, 7'h05, 16'h0000);
		t_bridge(8'h00, 7'h07, 16'h0000);
		t_bridge(8'h03, 7'h00, 16'h0000);
		wrap_up();
	end

	// Watchdog
	initial begin
		#(40 * 40000);
		bad_count++;
		wrap_up();
	end
endmodule
